// *** rtl/chain_port_pkg.sv ***
/*
  Constants shared by the daisy-chain serial port: command codes, check modes,
  CRC polynomials and sizes.
  Assumes the serial master follows the command framing described here.
*/
package chain_port_pkg;

  localparam logic [3:0] WRITE_NIB = 4'h5;
  localparam logic [3:0] READ_NIB = 4'h1;
  localparam logic [7:0] OP_SINGLE_READ = 8'h01;
  localparam logic [7:0] OP_CONT_READ = 8'h03;
  localparam logic [7:0] OP_STOP_CONT = 8'h0F;
  localparam logic [7:0] OP_STANDBY = 8'hFD;
  localparam logic [7:0] OP_WAKE = 8'hFF;
  localparam logic [7:0] OP_BCAST_PREFIX = 8'hFE;
  localparam logic [2:0] DIRECTED_TOP = 3'h6;
  localparam logic [2:0] ID_ASSIGN_TOP = 3'h5;

  localparam logic [1:0] CHECK_OFF = 2'h0;
  localparam logic [1:0] CHECK_XOR = 2'h1;
  localparam logic [1:0] CHECK_CRC8 = 2'h2;
  localparam logic [1:0] CHECK_CRC4 = 2'h3;
  localparam logic [7:0] CRC8_POLY = 8'h07;
  localparam logic [3:0] CRC4_POLY = 4'h3;

  localparam int REG_COUNT = 16;
  localparam logic [5:0] RESULT_BYTES = 6'h03;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [4:0] ID_RESET = 5'h00;

endpackage

// *** rtl/check_step.sv ***
/*
  One byte step of the check engine: XOR, CRC-8 or CRC-4 (two nibble chunks).
  Purely combinational; the caller holds the running value.
*/
`timescale 1ns/1ps
module check_step
  import chain_port_pkg::*;
(
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data,
  input wire logic [1:0] mode,
  output logic [7:0] crc_out
);

  logic [7:0] s8;
  logic [3:0] s4;

  always_comb begin
    s8 = crc_in ^ data;
    s4 = crc_in[3:0] ^ data[7:4];
    for (int i = 0; i < 8; i++) begin
      s8 = s8[7] ? ({s8[6:0], 1'b0} ^ CRC8_POLY) : {s8[6:0], 1'b0};
    end
    for (int i = 0; i < 4; i++) begin
      s4 = s4[3] ? ({s4[2:0], 1'b0} ^ CRC4_POLY) : {s4[2:0], 1'b0};
    end
    s4 = s4 ^ data[3:0];
    for (int i = 0; i < 4; i++) begin
      s4 = s4[3] ? ({s4[2:0], 1'b0} ^ CRC4_POLY) : {s4[2:0], 1'b0};
    end
    unique case (mode)
      CHECK_XOR: crc_out = crc_in ^ data;
      CHECK_CRC8: crc_out = s8;
      CHECK_CRC4: crc_out = {4'h0, s4};
      default: crc_out = 8'h00;
    endcase
  end

endmodule

// *** rtl/chain_port.sv ***
/*
  Daisy-chainable serial command port with check-byte protection.
  Link logic runs on sclk; register writes, error and id reach mclk by toggles, standby by a level synchronizer.
  Assumes the converter core drives conversion_result on mclk.
*/
`timescale 1ns/1ps
// How it works
// - In chain mode the data output is always driven, never released.
// - Chip select high resets the frame logic and passes din straight to dout.
// - Broadcast id assign numbers devices upward, wrapping 31 to 0.
// - In chain mode read answers come one byte later.
// - After continuous read in chain mode commands wait for a select pulse.
// - Standby ends only on the all-ones wake byte.
// - Check mode two uses CRC-8 with polynomial 0x07.
// - A write with a wrong check byte is dropped and flags an error.
// - Check mode three uses CRC-4 with polynomial 0x3.
// - Check mode one uses the XOR of the bytes.
// - With a check mode set, the result checksum setting appends a check byte after the result.
// - CRC clears, takes data MSB first, shifts with conditional polynomial.
module chain_port
  import chain_port_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  input wire logic daisy_mode,
  input wire logic [1:0] check_mode,
  input wire logic result_checksum_enable,
  input wire logic [23:0] conversion_result,
  input wire logic conversion_ready_n,
  input wire logic crc_err_clear,
  output logic crc_err,
  output logic reg_wr_stb,
  output logic [3:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  output logic [4:0] chain_id,
  output logic standby
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_WCOUNT = 3'b010,
    ST_WDATA = 3'b011,
    ST_WCHECK = 3'b100,
    ST_RCOUNT = 3'b101
  } frame_state_t;

  typedef enum logic [1:0] {
    SRC_FWD = 2'b00,
    SRC_REG = 2'b01,
    SRC_RES = 2'b10,
    SRC_CRC = 2'b11
  } tx_src_t;

  // Chip select high clears all frame state; sclk may be stopped then.
  logic frame_rst;
  assign frame_rst = rst | cs_n;

  logic [3:0] cfg_meta_r, cfg_r;
  logic cfg_daisy;
  logic [1:0] cfg_mode;
  logic cfg_chk;
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      cfg_meta_r <= 4'h0;
      cfg_r <= 4'h0;
    end else begin
      cfg_meta_r <= {result_checksum_enable, check_mode, daisy_mode};
      cfg_r <= cfg_meta_r;
    end
  end
  assign cfg_daisy = cfg_r[0];
  assign cfg_mode = cfg_r[2:1];
  assign cfg_chk = cfg_r[3];

  logic res_tg_r, res_s1_r, res_s2_r, res_s3_r;
  logic [23:0] res_hold_r, res_link_r;
  logic res_new;
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      res_s1_r <= 1'b0;
      res_s2_r <= 1'b0;
      res_s3_r <= 1'b0;
      res_link_r <= 24'h00_0000;
    end else begin
      res_s1_r <= res_tg_r;
      res_s2_r <= res_s1_r;
      res_s3_r <= res_s2_r;
      if (res_s2_r != res_s3_r) begin
        res_link_r <= res_hold_r;
      end
    end
  end
  assign res_new = res_s2_r != res_s3_r;

  logic [2:0] bit_cnt_r;
  logic [6:0] rx_sh_r;
  logic [7:0] rx_byte;
  logic byte_done;
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_r <= 3'h0;
      rx_sh_r <= 7'h00;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_sh_r <= {rx_sh_r[5:0], din};
    end
  end
  assign rx_byte = {rx_sh_r, din};
  assign byte_done = bit_cnt_r == 3'h7;

  frame_state_t state_r;
  logic addressed_r, bcast_r, lock_r, cont_r, standby_r;
  logic [4:0] chain_id_r;
  logic [3:0] wr_addr_r;
  logic [7:0] wr_data_r, calc_r, calc_nxt;
  logic [7:0] regfile_r [REG_COUNT];

  logic accept, is_bcast, is_directed, cmd_valid, cmd_addr, cmd_bcast, is_id_assign;
  logic commit, reject, arm_reg, arm_res;
  logic [7:0] check_expect;

  // A chained device locked by continuous read hears nothing until select pulses.
  assign accept = byte_done && !(cfg_daisy && lock_r) && !standby_r;
  assign is_bcast = rx_byte == OP_BCAST_PREFIX;
  assign is_directed = rx_byte[7:5] == DIRECTED_TOP;
  assign cmd_valid = accept && ((state_r == ST_IDLE && !is_bcast && !is_directed)
                     || state_r == ST_CMD);
  assign cmd_addr = (state_r == ST_CMD) ? addressed_r : 1'b1;
  assign cmd_bcast = (state_r == ST_CMD) && bcast_r;
  assign is_id_assign = rx_byte[7:5] == ID_ASSIGN_TOP;
  assign check_expect = (cfg_mode == CHECK_CRC4) ? {calc_r[3:0], 4'h0} : calc_r;
  assign commit = addressed_r && accept && ((state_r == ST_WDATA && cfg_mode == CHECK_OFF)
                  || (state_r == ST_WCHECK && rx_byte == check_expect));
  assign reject = addressed_r && accept && state_r == ST_WCHECK
                  && rx_byte != check_expect;
  assign arm_reg = addressed_r && accept && state_r == ST_RCOUNT;
  assign arm_res = (cmd_valid && cmd_addr && rx_byte == OP_SINGLE_READ)
                   || (cont_r && res_new);

  check_step u_calc (
    .crc_in(state_r == ST_CMD || state_r == ST_IDLE ? 8'h00 : calc_r),
    .data(rx_byte),
    .mode(cfg_mode),
    .crc_out(calc_nxt)
  );

  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      state_r <= ST_IDLE;
      addressed_r <= 1'b0;
      bcast_r <= 1'b0;
      calc_r <= 8'h00;
      wr_addr_r <= 4'h0;
      wr_data_r <= 8'h00;
    end else if (accept) begin
      unique case (state_r)
        ST_IDLE: begin
          bcast_r <= is_bcast;
          addressed_r <= is_bcast || (is_directed && rx_byte[4:0] == chain_id_r);
          if (is_bcast || is_directed) begin
            state_r <= ST_CMD;
          end
        end
        ST_WCOUNT: begin
          state_r <= ST_WDATA;
        end
        ST_WDATA: begin
          wr_data_r <= rx_byte;
          state_r <= (cfg_mode == CHECK_OFF) ? ST_IDLE : ST_WCHECK;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
      calc_r <= calc_nxt;
      if (cmd_valid) begin
        addressed_r <= cmd_addr;
        wr_addr_r <= rx_byte[3:0];
        if (rx_byte[7:4] == WRITE_NIB) begin
          state_r <= ST_WCOUNT;
        end else if (rx_byte[7:4] == READ_NIB) begin
          state_r <= ST_RCOUNT;
        end else begin
          state_r <= ST_IDLE;
        end
      end
    end
  end

  // Lock is cleared by the select pulse through the frame reset.
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      lock_r <= 1'b0;
    end else if (cmd_valid && cmd_addr && rx_byte == OP_CONT_READ && cfg_daisy) begin
      lock_r <= 1'b1;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      cont_r <= 1'b0;
      standby_r <= 1'b0;
      chain_id_r <= ID_RESET;
    end else begin
      if (cmd_valid && cmd_addr && rx_byte == OP_CONT_READ) begin
        cont_r <= 1'b1;
      end else if (cmd_valid && cmd_addr && rx_byte == OP_STOP_CONT) begin
        cont_r <= 1'b0;
      end
      if (cmd_valid && cmd_addr && rx_byte == OP_STANDBY) begin
        standby_r <= 1'b1;
      end else if (byte_done && !cs_n && rx_byte == OP_WAKE) begin
        standby_r <= 1'b0;
      end
      if (cmd_valid && cmd_addr && is_id_assign) begin
        chain_id_r <= rx_byte[4:0];
      end
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regfile_r[i] <= REG_RESET;
      end
    end else if (commit) begin
      regfile_r[wr_addr_r] <= (state_r == ST_WDATA) ? rx_byte : wr_data_r;
    end
  end

  tx_src_t src_r, pend_r, pick, src_nxt;
  logic gap_r, gap_nxt, pend_clr;
  logic [5:0] left_r, left_nxt, rd_len_r;
  logic [3:0] ptr_r, ptr_nxt, rd_base_r;
  logic [7:0] tx_r, tx_byte, out_crc_r, out_crc_nxt, fwd_byte, step_out;
  logic tx_check;
  tx_src_t pend_now;
  logic [3:0] base_now;
  logic [5:0] len_now;

  // Outside chain mode an answer armed by the current byte starts at once, without a wasted byte.
  assign pend_now = arm_reg ? SRC_REG : (arm_res ? SRC_RES : pend_r);
  assign base_now = arm_reg ? wr_addr_r : rd_base_r;
  assign len_now = arm_reg ? ({1'b0, rx_byte[4:0]} + 6'h01) : rd_len_r;

  // Each later device in the chain sees the assigned number plus one.
  assign fwd_byte = (cmd_valid && cmd_bcast && is_id_assign)
                    ? {ID_ASSIGN_TOP, 5'(rx_byte[4:0] + 5'h01)} : rx_byte;

  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      pend_r <= SRC_FWD;
      rd_base_r <= 4'h0;
      rd_len_r <= 6'h00;
    end else begin
      if (arm_reg) begin
        rd_base_r <= wr_addr_r;
        rd_len_r <= len_now;
      end
      // A request served at once must not stay pending for a second answer.
      if (pend_clr) begin
        pend_r <= SRC_FWD;
      end else begin
        pend_r <= pend_now;
      end
    end
  end

  check_step u_out (
    .crc_in((pick == src_r) ? out_crc_r : 8'h00),
    .data(tx_byte),
    .mode(cfg_mode),
    .crc_out(step_out)
  );

  always_comb begin
    pick = src_r;
    pend_clr = 1'b0;
    gap_nxt = gap_r;
    tx_check = cfg_mode != CHECK_OFF;
    if (src_r == SRC_FWD && pend_now != SRC_FWD && byte_done) begin
      // A chained device spends one extra byte before answering.
      if (cfg_daisy && !gap_r) begin
        gap_nxt = 1'b1;
      end else begin
        pick = pend_now;
        pend_clr = 1'b1;
        gap_nxt = 1'b0;
      end
    end
    left_nxt = left_r;
    ptr_nxt = ptr_r;
    src_nxt = pick;
    out_crc_nxt = out_crc_r;
    unique case (pick)
      SRC_REG: begin
        if (src_r != SRC_REG) begin
          ptr_nxt = base_now;
          left_nxt = len_now;
          out_crc_nxt = 8'h00;
        end
        tx_byte = regfile_r[ptr_nxt];
        ptr_nxt = ptr_nxt + 4'h1;
        left_nxt = left_nxt - 6'h01;
      end
      SRC_RES: begin
        if (src_r != SRC_RES) begin
          left_nxt = RESULT_BYTES;
          out_crc_nxt = 8'h00;
        end
        tx_byte = (left_nxt == 6'h03) ? res_link_r[23:16]
                  : (left_nxt == 6'h02) ? res_link_r[15:8] : res_link_r[7:0];
        left_nxt = left_nxt - 6'h01;
        tx_check = tx_check && cfg_chk;
      end
      SRC_CRC: begin
        tx_byte = (cfg_mode == CHECK_CRC4) ? {out_crc_r[3:0], 4'h0} : out_crc_r;
        src_nxt = SRC_FWD;
      end
      default: begin
        tx_byte = cfg_daisy ? fwd_byte : 8'h00;
      end
    endcase
    if (pick == SRC_REG || pick == SRC_RES) begin
      out_crc_nxt = step_out;
      if (left_nxt == 6'h00) begin
        src_nxt = tx_check ? SRC_CRC : SRC_FWD;
      end
    end
  end

  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      tx_r <= 8'h00;
      src_r <= SRC_FWD;
      gap_r <= 1'b0;
      left_r <= 6'h00;
      ptr_r <= 4'h0;
      out_crc_r <= 8'h00;
    end else if (byte_done) begin
      tx_r <= tx_byte;
      src_r <= src_nxt;
      gap_r <= gap_nxt;
      left_r <= left_nxt;
      ptr_r <= ptr_nxt;
      out_crc_r <= out_crc_nxt;
    end else begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // The bypass path must be combinational so a deselected device adds no delay.
  assign dout = cs_n ? din : tx_r[7];

  logic wr_tg_r, err_tg_r, id_tg_r;
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      wr_tg_r <= 1'b0;
      err_tg_r <= 1'b0;
      id_tg_r <= 1'b0;
    end else begin
      wr_tg_r <= wr_tg_r ^ commit;
      err_tg_r <= err_tg_r ^ reject;
      id_tg_r <= id_tg_r ^ (cmd_valid && cmd_addr && is_id_assign);
    end
  end

  logic [2:0] wr_sy_r, err_sy_r, id_sy_r;
  logic [1:0] cs_sy_r, sb_sy_r;
  logic ready_prev_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_sy_r <= 3'h0;
      err_sy_r <= 3'h0;
      id_sy_r <= 3'h0;
      cs_sy_r <= 2'h3;
      sb_sy_r <= 2'h0;
    end else begin
      wr_sy_r <= {wr_sy_r[1:0], wr_tg_r};
      err_sy_r <= {err_sy_r[1:0], err_tg_r};
      id_sy_r <= {id_sy_r[1:0], id_tg_r};
      cs_sy_r <= {cs_sy_r[0], cs_n};
      sb_sy_r <= {sb_sy_r[0], standby_r};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_wr_stb <= 1'b0;
      reg_wr_addr <= 4'h0;
      reg_wr_data <= 8'h00;
      chain_id <= ID_RESET;
    end else begin
      reg_wr_stb <= wr_sy_r[2] != wr_sy_r[1];
      if (wr_sy_r[2] != wr_sy_r[1]) begin
        reg_wr_addr <= wr_addr_r;
        reg_wr_data <= wr_data_r;
      end
      if (id_sy_r[2] != id_sy_r[1]) begin
        chain_id <= chain_id_r;
      end
    end
  end

  // Set wins over clear so a rejection in the clearing cycle is kept.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      crc_err <= 1'b0;
    end else if (err_sy_r[2] != err_sy_r[1]) begin
      crc_err <= 1'b1;
    end else if (crc_err_clear) begin
      crc_err <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dout_oe <= 1'b0;
      standby <= 1'b0;
    end else begin
      dout_oe <= daisy_mode || !cs_sy_r[1];
      standby <= sb_sy_r[1];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ready_prev_r <= 1'b1;
      res_tg_r <= 1'b0;
      res_hold_r <= 24'h00_0000;
    end else begin
      ready_prev_r <= conversion_ready_n;
      if (ready_prev_r && !conversion_ready_n) begin
        res_hold_r <= conversion_result;
        res_tg_r <= !res_tg_r;
      end
    end
  end

endmodule

// *** testbench/chain_port_props.sv ***
/*
  Concurrent checks on the ports of the daisy-chain serial port.
  Assumes one mclk domain for the checked outputs and rst active high.
*/
`timescale 1ns/1ps
module chain_port_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic daisy_mode,
  input wire logic crc_err_clear,
  input wire logic crc_err,
  input wire logic reg_wr_stb,
  input wire logic [3:0] reg_wr_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic standby
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_oe_daisy;
    daisy_mode [*3] |-> dout_oe;
  endproperty
  a_oe_daisy: assert property (p_oe_daisy) else $error("output released in chain mode");

  property p_oe_idle;
    (!daisy_mode && cs_n) [*5] |-> !dout_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven while idle");

  property p_oe_sel;
    $fell(cs_n) |-> ##[1:4] dout_oe;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("output not driven after select");

  property p_bypass;
    cs_n |-> dout == din;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass path broken");

  property p_stb_pulse;
    reg_wr_stb |=> !reg_wr_stb;
  endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("write strobe too long");

  property p_wr_hold;
    !reg_wr_stb |-> $stable(reg_wr_addr) && $stable(reg_wr_data);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write fields moved");

  property p_err_hold;
    crc_err && !crc_err_clear |=> crc_err;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped");

  property p_err_clear;
    crc_err_clear |=> !crc_err;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");

  property p_err_nostb;
    $rose(crc_err) |-> !reg_wr_stb [*4];
  endproperty
  a_err_nostb: assert property (p_err_nostb) else $error("rejected write strobed");

  c_write: cover property (reg_wr_stb);
  c_err: cover property ($rose(crc_err));
  c_standby: cover property ($rose(standby));
  c_chain: cover property (daisy_mode && !cs_n);
endmodule

bind chain_port chain_port_props i_props (
  .mclk(mclk),
  .rst(rst),
  .cs_n(cs_n),
  .din(din),
  .dout(dout),
  .dout_oe(dout_oe),
  .daisy_mode(daisy_mode),
  .crc_err_clear(crc_err_clear),
  .crc_err(crc_err),
  .reg_wr_stb(reg_wr_stb),
  .reg_wr_addr(reg_wr_addr),
  .reg_wr_data(reg_wr_data),
  .standby(standby)
);

// *** testbench/serial_master_model.sv ***
/*
  Serial master: makes sclk (64 ns) only inside frames, drives din MSB first.
  Assumes the device takes din on rising sclk and moves dout after it.
*/
`timescale 1ns/1ps
module serial_master_model (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b1;
  end

  // Dout is taken just before each rising edge, so rx byte k is frame byte k.
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    #3 cs_n = 1'b0;
    #40;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        b[k] = dout;
        din = tx[i][k];
        #32 sclk = 1'b1;
        #32 sclk = 1'b0;
      end
      rx.push_back(b);
    end
    #40 cs_n = 1'b1;
    // A released line must not keep its last bit, or stale data could pass.
    din = ~din;
    #200;
  endtask
endmodule

// *** testbench/tb.sv ***
/*
  Self-checking bench of the daisy-chain serial port.
  Assumes the serial master model drives sclk, cs_n and din.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
  import chain_port_pkg::*;
  typedef struct {logic [1:0] m; logic [3:0] a; logic [7:0] d; logic ok;} row_t;
  logic mclk, rst, sclk, cs_n, din, dout, dout_oe, daisy_mode, result_checksum_enable;
  logic conversion_ready_n, crc_err_clear, crc_err, reg_wr_stb, standby;
  logic [1:0] check_mode;
  logic [23:0] conversion_result;
  logic [3:0] reg_wr_addr;
  logic [7:0] reg_wr_data, v;
  logic [4:0] chain_id;
  logic [7:0] regs[16];
  logic [7:0] r[$];
  int bad_count, n_tests, stb_n, s0, cyc;
  row_t rows[8] = '{'{CHECK_OFF, 4'h3, 8'h5A, 1}, '{CHECK_XOR, 4'h4, 8'hC3, 1},
    '{CHECK_XOR, 4'h4, 8'h11, 0}, '{CHECK_CRC8, 4'h5, 8'h5A, 1},
    '{CHECK_CRC8, 4'h6, 8'h77, 0}, '{CHECK_CRC4, 4'h5, 8'hEA, 1},
    '{CHECK_CRC4, 4'h7, 8'h01, 0}, '{CHECK_CRC8, 4'hF, 8'hFF, 1}};

  chain_port i_dut (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .dout_oe(dout_oe), .daisy_mode(daisy_mode), .check_mode(check_mode),
    .result_checksum_enable(result_checksum_enable), .conversion_result(conversion_result),
    .conversion_ready_n(conversion_ready_n), .crc_err_clear(crc_err_clear),
    .crc_err(crc_err), .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .chain_id(chain_id), .standby(standby));
  serial_master_model i_mst (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    stb_n = stb_n + (reg_wr_stb === 1'b1 ? 1 : 0);
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      finish_test();
    end
  end

  function automatic logic [7:0] chk(input logic [1:0] m, input logic [7:0] q[$]);
    logic [7:0] c;
    logic [3:0] c4;
    c = 8'h00;
    c4 = 4'h0;
    foreach (q[i]) begin
      if (m == CHECK_XOR) c = c ^ q[i];
      if (m == CHECK_CRC8) begin
        c = c ^ q[i];
        repeat (8) c = c[7] ? (c << 1) ^ CRC8_POLY : c << 1;
      end
      if (m == CHECK_CRC4) for (int h = 1; h >= 0; h--) begin
        c4 = c4 ^ q[i][4*h +: 4];
        repeat (4) c4 = c4[3] ? (c4 << 1) ^ CRC4_POLY : c4 << 1;
      end
    end
    return (m == CHECK_CRC4) ? {c4, 4'h0} : c;
  endfunction

  task automatic cmd(input logic [7:0] q[$]);
    i_mst.frame(q, r);
    repeat (20) @(posedge mclk);
  endtask

  task automatic wr(input logic [1:0] m, input logic [3:0] a, input logic [7:0] d,
                    input logic ok);
    logic [7:0] q[$];
    logic [7:0] c;
    q = '{{WRITE_NIB, a}, 8'h00, d};
    c = chk(m, q);
    if (m != CHECK_OFF) q.push_back(ok ? c : ~c);
    cmd(q);
  endtask

  task automatic rd(input logic [3:0] a, input int pos);
    cmd('{{READ_NIB, a}, 8'h00, 8'hFF, 8'hFF, 8'hFF});
    v = r[pos];
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    daisy_mode = 1'b0;
    check_mode = CHECK_OFF;
    result_checksum_enable = 1'b0;
    conversion_result = 24'h00_0000;
    conversion_ready_n = 1'b1;
    crc_err_clear = 1'b0;
    foreach (regs[i]) regs[i] = REG_RESET;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    foreach (rows[i]) begin
      check_mode <= rows[i].m;
      s0 = stb_n;
      wr(rows[i].m, rows[i].a, rows[i].d, rows[i].ok);
      `CHK(stb_n - s0, rows[i].ok ? 1 : 0)
      `CHK(crc_err, !rows[i].ok)
      if (rows[i].ok) begin
        regs[rows[i].a] = rows[i].d;
        `CHK(reg_wr_addr, rows[i].a)
        `CHK(reg_wr_data, rows[i].d)
      end
      rd(rows[i].a, 2);
      `CHK(v, regs[rows[i].a])
      @(posedge mclk) crc_err_clear <= 1'b1;
      @(posedge mclk) crc_err_clear <= 1'b0;
      @(posedge mclk);
      `CHK(crc_err, 1'b0)
      $display("test write row %0d done", i);
    end
    @(posedge mclk) rst <= 1'b1;
    check_mode <= CHECK_OFF;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK({crc_err, standby, chain_id, dout_oe}, {2'b00, ID_RESET, 1'b0})
    rd(4'h3, 2);
    `CHK(v, REG_RESET)
    `CHK(dout, din)
    $display("test reset done");
    cmd('{OP_BCAST_PREFIX, {ID_ASSIGN_TOP, 5'h1F}});
    `CHK(chain_id, 5'h1F)
    cmd('{{DIRECTED_TOP, 5'h1F}, {ID_ASSIGN_TOP, 5'h05}});
    `CHK(chain_id, 5'h05)
    cmd('{{DIRECTED_TOP, 5'h03}, {ID_ASSIGN_TOP, 5'h09}});
    `CHK(chain_id, 5'h05)
    $display("test id done");
    cmd('{OP_STANDBY});
    `CHK(standby, 1'b1)
    cmd('{OP_CONT_READ});
    `CHK(standby, 1'b1)
    cmd('{OP_WAKE});
    `CHK(standby, 1'b0)
    $display("test standby done");
    check_mode <= CHECK_CRC8;
    result_checksum_enable <= 1'b1;
    conversion_result <= 24'h65_4321;
    repeat (4) @(posedge mclk);
    conversion_ready_n <= 1'b0;
    repeat (10) @(posedge mclk);
    cmd('{OP_SINGLE_READ, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
    `CHK({r[1], r[2], r[3]}, 24'h65_4321)
    `CHK(r[4], 8'h86)
    conversion_ready_n <= 1'b1;
    check_mode <= CHECK_OFF;
    result_checksum_enable <= 1'b0;
    $display("test result checksum done");
    wr(CHECK_OFF, 4'h9, 8'hA5, 1);
    // Chain mode keeps check mode off: CRC-4 and bursts are avoided there.
    // The entry pattern is decoded elsewhere; the level port stands for it.
    // One device stands for the chain, so all chained devices share these settings.
    @(posedge mclk) daisy_mode <= 1'b1;
    repeat (10) @(posedge mclk);
    `CHK(dout_oe, 1'b1)
    rd(4'h9, 3);
    `CHK(v, 8'hA5)
    // The master clocks whole bytes only, so no frame ends mid-result.
    cmd('{OP_CONT_READ, OP_STANDBY});
    `CHK(standby, 1'b0)
    cmd('{OP_STOP_CONT});
    cmd('{OP_STANDBY});
    `CHK(standby, 1'b1)
    cmd('{OP_WAKE});
    `CHK(standby, 1'b0)
    $display("test chain mode done");
    // Leaving chain mode: the reset rises and the chain level drops in the same cycle.
    @(posedge mclk) rst <= 1'b1;
    daisy_mode <= 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK(dout_oe, 1'b0)
    $display("test chain exit done");
    finish_test();
  end
endmodule
